// File: inc/kbc_host_port_defs.vh
// Constants for the keyboard controller host data port.
// Assumes inclusion by the port's design file only.
`ifndef KBC_HOST_PORT_DEFS_VH
`define KBC_HOST_PORT_DEFS_VH

`define DATA_ADDR_DEFAULT 16'h0060
`define CMD_ADDR_DEFAULT 16'h0064
`define CMD_SELECT_BIT 2
`define STAT_OUTPUT_FULL 0
`define STAT_INPUT_FULL 1
`define STAT_USER_FLAG_ZERO 2
`define STAT_COMMAND_DATA 3
`define STAT_USER_HI_LSB 4
`define STATE_DIVIDE 3
`define STATES_PER_INSTR 5
`define CLOCKS_PER_INSTR 15
// Last value of each divider count, sized to its counter
`define STATE_COUNT_LAST 2'h2
`define PHASE_COUNT_LAST 3'h4
`define STATUS_RESET 8'h00

`endif

// File: hw/kbc_host_data_port.v
// Host data port of an embedded keyboard controller: host byte buffers,
// status register, interrupt latch and instruction-cycle timing.
// Assumes host strobes arrive asynchronously on pins; firmware side is on i_clock.
//
// Operation
// - The port answers at the data address with bit 2 low and at the command address with bit 2 high.
// - Software may relocate both port addresses after reset.
// - A host data read returns the controller-to-host byte, a command read returns status.
// - A host write to either port address loads the host-to-controller byte and records address bit 2 as the command flag.
// - The command flag sits in status bit 3; set means command, clear means data.
// - Firmware writing the controller-to-host byte sets status bit 0.
// - A host read of the data address clears status bit 0.
// - Each host write sets status bit 1 and may raise the firmware input interrupt when enabled.
// - The firmware input-read instruction clears status bit 1.
// - Status bit 2 is cleared or toggled only by firmware.
// - Status bits 7 to 4 are written only by firmware.
// - Status is read-only to the host.
// - The clock is divided by 3 into states and by 5 into 15-clock instruction cycles.
// - Instructions take one or two instruction cycles.
// - In latched mode a rising interrupt request is held until the host reads the data address.
`timescale 1ns/1ps
`default_nettype none
`include "kbc_host_port_defs.vh"

module kbc_host_data_port #(
  parameter ADDR_WIDTH = 16
) (
  // Clock, reset, enable
  input wire i_clock,
  input wire i_reset,
  input wire i_clock_enable,
  // Host I/O pins
  input wire [ADDR_WIDTH-1:0] i_host_addr,
  input wire i_host_read_n,
  input wire i_host_write_n,
  input wire [7:0] i_host_wdata,
  output reg [7:0] o_host_rdata,
  output reg o_host_rdata_oe,
  // Address relocation
  input wire i_addr_load,
  input wire [ADDR_WIDTH-1:0] i_data_addr,
  input wire [ADDR_WIDTH-1:0] i_cmd_addr,
  // Firmware side
  input wire i_fw_out_write,
  input wire [7:0] i_fw_out_data,
  input wire i_fw_read_input,
  input wire i_fw_flag0_clear,
  input wire i_fw_flag0_toggle,
  input wire i_fw_user_write,
  input wire [3:0] i_fw_user_data,
  input wire i_fw_ibf_int_enable,
  input wire i_fw_two_cycle,
  output reg [7:0] o_fw_in_data,
  output reg o_fw_ibf_int,
  output reg [7:0] o_status,
  // Instruction timing
  output reg o_state_strobe,
  output reg o_instr_strobe,
  output reg o_instr_done,
  // Interrupt request routing
  input wire i_irq_request,
  input wire i_irq_latched_mode,
  output reg o_host_irq
);

  reg [ADDR_WIDTH-1:0] addr_s1_q;
  reg [ADDR_WIDTH-1:0] addr_s2_q;
  reg [7:0] wdata_s1_q;
  reg [7:0] wdata_s2_q;
  reg rd_s1_q;
  reg rd_s2_q;
  reg rd_s3_q;
  reg wr_s1_q;
  reg wr_s2_q;
  reg wr_s3_q;
  reg [ADDR_WIDTH-1:0] data_addr_q;
  reg [ADDR_WIDTH-1:0] cmd_addr_q;
  reg [7:0] out_data_q;
  reg output_full_flag_q;
  reg input_full_flag_q;
  reg user_flag_zero_q;
  reg command_data_flag_q;
  reg [3:0] user_flags_q;
  reg [1:0] state_cnt_q;
  reg [2:0] phase_cnt_q;
  reg second_cycle_q;
  reg irq_prev_q;
  reg irq_latch_q;

  wire rd_active;
  wire wr_active;
  wire wr_start;
  wire rd_end;
  wire hit_data;
  wire hit_cmd;
  wire host_data_read;
  wire host_write;
  wire state_tick;
  wire instr_tick;
  wire [7:0] status_now;
  wire irq_rise;

  // Decode: the bit-2 level must agree with the matched address
  function addr_match;
    input [ADDR_WIDTH-1:0] addr;
    input [ADDR_WIDTH-1:0] base;
    begin
      addr_match = (addr == base);
    end
  endfunction

  assign rd_active = rd_s2_q;
  assign wr_active = wr_s2_q;
  // One write per strobe: act on the first synced low sample only
  assign wr_start = wr_s2_q && !wr_s3_q;
  // Clear on strobe release so the host samples the byte before the flag drops
  assign rd_end = !rd_s2_q && rd_s3_q;
  // Full-address match plus the bit-2 level keeps aliases out
  assign hit_data = addr_match(addr_s2_q, data_addr_q) && !addr_s2_q[`CMD_SELECT_BIT];
  assign hit_cmd = addr_match(addr_s2_q, cmd_addr_q) && addr_s2_q[`CMD_SELECT_BIT];
  assign host_data_read = rd_end && hit_data;
  assign host_write = wr_start && (hit_data || hit_cmd);
  assign state_tick = (state_cnt_q == `STATE_COUNT_LAST);
  assign instr_tick = state_tick && (phase_cnt_q == `PHASE_COUNT_LAST);
  // Requests count as edges only in latched mode
  assign irq_rise = i_irq_latched_mode && i_irq_request && !irq_prev_q;
  assign status_now = {user_flags_q, command_data_flag_q, user_flag_zero_q,
                       input_full_flag_q, output_full_flag_q};

  // Pin synchronisers
  always @(posedge i_clock) begin
    if (i_reset) begin
      addr_s1_q <= {ADDR_WIDTH{1'b0}};
      addr_s2_q <= {ADDR_WIDTH{1'b0}};
      wdata_s1_q <= 8'h00;
      wdata_s2_q <= 8'h00;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      rd_s3_q <= 1'b0;
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else if (i_clock_enable) begin
      addr_s1_q <= i_host_addr;
      addr_s2_q <= addr_s1_q;
      wdata_s1_q <= i_host_wdata;
      wdata_s2_q <= wdata_s1_q;
      rd_s1_q <= !i_host_read_n;
      rd_s2_q <= rd_s1_q;
      rd_s3_q <= rd_s2_q;
      wr_s1_q <= !i_host_write_n;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end

  // Port addresses
  // Relocation acts from the next strobe; a transfer in flight may miss
  always @(posedge i_clock) begin
    if (i_reset) begin
      data_addr_q <= `DATA_ADDR_DEFAULT;
      cmd_addr_q <= `CMD_ADDR_DEFAULT;
    end else if (i_clock_enable && i_addr_load) begin
      data_addr_q <= i_data_addr;
      cmd_addr_q <= i_cmd_addr;
    end
  end

  // Controller-to-host buffer; a firmware load beats a same-cycle host read
  always @(posedge i_clock) begin
    if (i_reset) begin
      out_data_q <= 8'h00;
      output_full_flag_q <= 1'b0;
    end else if (i_clock_enable) begin
      if (i_fw_out_write) begin
        out_data_q <= i_fw_out_data;
        output_full_flag_q <= 1'b1;
      end else if (host_data_read) begin
        output_full_flag_q <= 1'b0;
      end
    end
  end

  // Host-to-controller buffer; a host write beats a same-cycle firmware fetch
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_fw_in_data <= 8'h00;
      input_full_flag_q <= 1'b0;
      command_data_flag_q <= 1'b0;
    end else if (i_clock_enable) begin
      if (host_write) begin
        o_fw_in_data <= wdata_s2_q;
        command_data_flag_q <= addr_s2_q[`CMD_SELECT_BIT];
        input_full_flag_q <= 1'b1;
      end else if (i_fw_read_input) begin
        input_full_flag_q <= 1'b0;
      end
    end
  end

  // Firmware-only flags; the host has no path into them
  always @(posedge i_clock) begin
    if (i_reset) begin
      user_flag_zero_q <= 1'b0;
      user_flags_q <= 4'h0;
    end else if (i_clock_enable) begin
      if (i_fw_flag0_clear) begin
        user_flag_zero_q <= 1'b0;
      end else if (i_fw_flag0_toggle) begin
        user_flag_zero_q <= !user_flag_zero_q;
      end
      if (i_fw_user_write) begin
        user_flags_q <= i_fw_user_data;
      end
    end
  end

  // Status copy and firmware input interrupt, one clock behind the flags
  // Interrupt follows the enable one clock later; it is not latched
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_status <= `STATUS_RESET;
      o_fw_ibf_int <= 1'b0;
    end else if (i_clock_enable) begin
      o_status <= status_now;
      o_fw_ibf_int <= input_full_flag_q && i_fw_ibf_int_enable;
    end
  end

  // Host read path; status has no host write path
  always @(posedge i_clock) begin
    if (i_reset) begin
      o_host_rdata <= 8'h00;
      o_host_rdata_oe <= 1'b0;
    end else if (i_clock_enable) begin
      o_host_rdata_oe <= rd_active && (hit_data || hit_cmd);
      if (hit_data) begin
        o_host_rdata <= out_data_q;
      end else if (hit_cmd) begin
        o_host_rdata <= status_now;
      end
    end
  end

  // State divider: free-running, no phase tie to host accesses
  always @(posedge i_clock) begin
    if (i_reset) begin
      state_cnt_q <= 2'd0;
      o_state_strobe <= 1'b0;
    end else if (i_clock_enable) begin
      state_cnt_q <= state_tick ? 2'd0 : state_cnt_q + 2'd1;
      o_state_strobe <= state_tick;
    end
  end

  // Instruction cycles; a two-cycle instruction ends on every second strobe
  always @(posedge i_clock) begin
    if (i_reset) begin
      phase_cnt_q <= 3'd0;
      second_cycle_q <= 1'b0;
      o_instr_strobe <= 1'b0;
      o_instr_done <= 1'b0;
    end else if (i_clock_enable) begin
      if (state_tick) begin
        phase_cnt_q <= instr_tick ? 3'd0 : phase_cnt_q + 3'd1;
      end
      o_instr_strobe <= instr_tick;
      o_instr_done <= 1'b0;
      if (instr_tick) begin
        if (i_fw_two_cycle && !second_cycle_q) begin
          second_cycle_q <= 1'b1;
        end else begin
          second_cycle_q <= 1'b0;
          o_instr_done <= 1'b1;
        end
      end
    end
  end

  // Host interrupt request: pass or latch
  always @(posedge i_clock) begin
    if (i_reset) begin
      irq_prev_q <= 1'b0;
      irq_latch_q <= 1'b0;
      o_host_irq <= 1'b0;
    end else if (i_clock_enable) begin
      irq_prev_q <= i_irq_request;
      // Leaving latched mode drops a held request so it cannot reappear later
      if (irq_rise) begin
        irq_latch_q <= 1'b1;
      end else if (host_data_read || !i_irq_latched_mode) begin
        irq_latch_q <= 1'b0;
      end
      // host may poll bit 0 instead of using this line
      if (i_irq_latched_mode) begin
        o_host_irq <= irq_latch_q || irq_rise;
      end else begin
        o_host_irq <= i_irq_request;
      end
    end
  end

endmodule // kbc_host_data_port

`default_nettype wire

// File: tb/kbc_host_data_port_monitor.sv
// Concurrent checks on the host data port pins.
// Assumes host strobes are held low four clocks or more.
`timescale 1ns/1ps
`default_nettype none
module kbc_host_data_port_monitor (
  // Clock and control
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_enable,
  // Host strobes and read drive
  input wire logic i_host_read_n,
  input wire logic i_host_write_n,
  input wire logic o_host_rdata_oe,
  // Firmware controls
  input wire logic i_fw_out_write,
  input wire logic i_fw_user_write,
  input wire logic [3:0] i_fw_user_data,
  input wire logic i_fw_ibf_int_enable,
  // Status, interrupt and timing
  input wire logic o_fw_ibf_int,
  input wire logic [7:0] o_status,
  input wire logic o_state_strobe,
  input wire logic o_instr_strobe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset || !i_clock_enable);
  sequence instr_gap;
    !o_instr_strobe [*8] ##7 o_instr_strobe;
  endsequence
  chk_state_period: assert property (o_state_strobe |=> !o_state_strobe [*2] ##1 o_state_strobe)
    else $error("state period");
  chk_instr_period: assert property (o_instr_strobe |=> instr_gap)
    else $error("instruction period");
  chk_out_set: assert property (i_fw_out_write |-> ##2 o_status[0])
    else $error("output full not set");
  chk_out_clear: assert property ($fell(o_status[0]) |-> $past(o_host_rdata_oe, 2))
    else $error("output full cleared alone");
  chk_read_drive: assert property (o_host_rdata_oe |-> !$past(i_host_read_n, 3))
    else $error("read data without read");
  chk_cmd_flag: assert property ($changed(o_status[3]) |-> !$past(i_host_write_n, 4))
    else $error("command flag without write");
  chk_input_int: assert property (o_fw_ibf_int == (o_status[1] && $past(i_fw_ibf_int_enable)))
    else $error("input interrupt wrong");
  chk_user_flags: assert property ($changed(o_status[7:4]) |->
      $past(i_fw_user_write, 2) && o_status[7:4] == $past(i_fw_user_data, 2))
    else $error("user flags wrong");
endmodule // kbc_host_data_port_monitor
bind kbc_host_data_port kbc_host_data_port_monitor kbc_host_data_port_monitor_i (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_clock_enable(i_clock_enable),
  .i_host_read_n(i_host_read_n),
  .i_host_write_n(i_host_write_n),
  .o_host_rdata_oe(o_host_rdata_oe),
  .i_fw_out_write(i_fw_out_write),
  .i_fw_user_write(i_fw_user_write),
  .i_fw_user_data(i_fw_user_data),
  .i_fw_ibf_int_enable(i_fw_ibf_int_enable),
  .o_fw_ibf_int(o_fw_ibf_int),
  .o_status(o_status),
  .o_state_strobe(o_state_strobe),
  .o_instr_strobe(o_instr_strobe)
);
`default_nettype wire

// File: tb/host_io_model.sv
// Host chipset model issuing timed I/O reads and writes.
// Assumes strobes are sampled on the rising clock.
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
  input wire logic i_clock,
  input wire logic [8:0] i_rdata,
  output logic [15:0] o_addr = '0,
  output logic o_read_n = 1'b1,
  output logic o_write_n = 1'b1,
  output logic [7:0] o_wdata = '0
);
  // Address held a clock past the strobe; released bus shows inverted values
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input int n,
      output logic [8:0] q);
    @(negedge i_clock);
    {o_addr, o_wdata} = {a, d};
    {o_write_n, o_read_n} = {!w, w};
    repeat (n) @(negedge i_clock);
    q = i_rdata;
    {o_write_n, o_read_n} = 2'b11;
    @(negedge i_clock);
    {o_addr, o_wdata} = ~{a, d};
    repeat (4) @(negedge i_clock);
  endtask
endmodule // host_io_model
`default_nettype wire

// File: tb/test_kbc_host_data_port.sv
// Random and corner tests of the host data port.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_kbc_host_data_port;
  logic i_clock = '0, i_reset = '1, i_fw_out_write = '0, i_fw_read_input = '0, i_fw_flag0_clear = '0;
  logic i_fw_flag0_toggle = '0, i_fw_user_write = '0, i_fw_ibf_int_enable = '0, i_fw_two_cycle = '0;
  logic i_addr_load = '0, i_irq_request = '0, i_irq_latched_mode = '0, i_clock_enable = '1;
  logic i_host_read_n, i_host_write_n, o_host_rdata_oe, o_fw_ibf_int, o_state_strobe, o_instr_strobe;
  logic o_instr_done, o_host_irq, input_full_flag = '0, output_full_flag = '0, cmd = '0, f0 = '0;
  logic [3:0] i_fw_user_data = '0, u = '0;
  logic [7:0] i_host_wdata, o_host_rdata, i_fw_out_data = '0, o_fw_in_data, o_status, d;
  logic [15:0] i_host_addr, i_data_addr = 16'h0120, i_cmd_addr = 16'h0124;
  logic [8:0] q;
  logic [23:0] n;
  int errors = 0, cmp_count = 0, cyc = 0, seed = 32'hff180009;
  kbc_host_data_port kbc_host_data_port_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
    .i_host_addr(i_host_addr), .i_host_read_n(i_host_read_n), .i_host_write_n(i_host_write_n),
    .i_host_wdata(i_host_wdata), .o_host_rdata(o_host_rdata), .o_host_rdata_oe(o_host_rdata_oe),
    .i_addr_load(i_addr_load), .i_data_addr(i_data_addr), .i_cmd_addr(i_cmd_addr),
    .i_fw_out_write(i_fw_out_write), .i_fw_out_data(i_fw_out_data), .i_fw_read_input(i_fw_read_input),
    .i_fw_flag0_clear(i_fw_flag0_clear), .i_fw_flag0_toggle(i_fw_flag0_toggle),
    .i_fw_user_write(i_fw_user_write), .i_fw_user_data(i_fw_user_data),
    .i_fw_ibf_int_enable(i_fw_ibf_int_enable), .i_fw_two_cycle(i_fw_two_cycle),
    .o_fw_in_data(o_fw_in_data), .o_fw_ibf_int(o_fw_ibf_int), .o_status(o_status),
    .o_state_strobe(o_state_strobe), .o_instr_strobe(o_instr_strobe), .o_instr_done(o_instr_done),
    .i_irq_request(i_irq_request), .i_irq_latched_mode(i_irq_latched_mode), .o_host_irq(o_host_irq));
  host_io_model host_io_model_i (.i_clock, .i_rdata({o_host_rdata_oe, o_host_rdata}), .o_addr(i_host_addr),
    .o_read_n(i_host_read_n), .o_write_n(i_host_write_n), .o_wdata(i_host_wdata));
  always #12.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      give_verdict;
    end
  end
  function automatic logic [7:0] stat();
    return {u, cmd, f0, input_full_flag, output_full_flag};
  endfunction
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clock) s = '1;
    @(negedge i_clock) s = '0;
    repeat (3) @(negedge i_clock);
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] v);
    host_io_model_i.xfer(w, a, v, 4 + ($random(seed) & 3), q);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_clock);
    i_reset = '0;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      i_fw_ibf_int_enable = d[1];
      {input_full_flag, cmd} = {1'b1, d[0]};
      io('1, {13'h000c, d[0], 2'h0}, d);
      check("input byte", d, o_fw_in_data);
      check("write status", stat(), o_status);
      check("input int", d[1], o_fw_ibf_int);
      pulse(i_fw_read_input);
      input_full_flag = '0;
      check("fetch status", stat(), o_status);
      i_fw_out_data = 8'($random(seed));
      pulse(i_fw_out_write);
      output_full_flag = '1;
      io('0, 16'h0064, d);
      check("status read", stat(), q[7:0]);
      io('0, 16'h0060, d);
      output_full_flag = '0;
      check("output byte", {1'b1, i_fw_out_data}, q);
      {u, i_fw_user_data} = {2{i_fw_out_data[7:4]}};
      pulse(i_fw_user_write);
      f0 = d[7] ? 1'b0 : ~f0;
      if (d[7])
        pulse(i_fw_flag0_clear);
      else
        pulse(i_fw_flag0_toggle);
      check("flags", stat(), o_status);
      $display("round %0d done", i);
    end
    io('1, 16'h0061, 8'h33);
    io('0, 16'h0062, 8'h33);
    check("stray access", stat(), {q[8], o_status});
    pulse(i_addr_load);
    io('1, 16'h0064, 8'h44);
    check("old address", stat(), o_status);
    io('1, 16'h0124, 8'h55);
    {input_full_flag, cmd} = 2'b11;
    check("new address", stat(), o_status);
    $display("address tests done");
    for (int k = 0; k < 2; k++) begin
      i_fw_two_cycle = k[0];
      n = '0;
      repeat (30) @(negedge i_clock);
      repeat (30) begin
        @(negedge i_clock);
        n += {7'h00, o_state_strobe, 7'h00, o_instr_strobe, 7'h00, o_instr_done};
      end
      check("timing", {8'h0a, 8'h02, 8'(2 - k)}, n);
    end
    i_irq_request = '1;
    repeat (2) @(negedge i_clock);
    check("irq passed", 1'b1, o_host_irq);
    i_irq_request = '0;
    repeat (2) @(negedge i_clock);
    check("irq dropped", 1'b0, o_host_irq);
    i_irq_latched_mode = '1;
    pulse(i_irq_request);
    check("irq latched", 1'b1, o_host_irq);
    io('0, 16'h0120, 8'h00);
    check("irq released", 1'b0, o_host_irq);
    $display("timing and irq tests done");
    pulse(i_fw_out_write);
    i_reset = '1;
    repeat (2) @(negedge i_clock);
    i_reset = '0;
    @(negedge i_clock);
    check("reset status", 8'h00, o_status);
    io('1, 16'h0060, 8'h5a);
    check("default after reset", 8'h5a, o_fw_in_data);
    give_verdict;
  end
endmodule // test_kbc_host_data_port
`default_nettype wire
